// ==== ltir_map.svh ====
`ifndef LTIR_MAP_SVH
`define LTIR_MAP_SVH

// ****************************************
// Register pointers
// ****************************************
`define LTIR_PTR_LOWER     8'h02
`define LTIR_PTR_UPPER     8'h03
`define LTIR_PTR_MAKER     8'h7e
`define LTIR_PTR_PART      8'h7f

// ****************************************
// Field positions
// ****************************************
`define LTIR_EXP_MSB       15
`define LTIR_EXP_LSB       12
`define LTIR_MANT_MSB      11
`define LTIR_MANT_LSB      0

// ****************************************
// Reset values and exponent limits
// ****************************************
`define LTIR_LOWER_RESET   16'h0000
`define LTIR_UPPER_RESET   16'hbfff
`define LTIR_EXP_MASK_LIM  4'hc
`define LTIR_EXP_MAX       4'hb

`endif

// ==== ltir_pkg.sv ====
`default_nettype none
package ltir_pkg;

  typedef struct packed {
    logic [3:0]  exponent;
    logic [11:0] mantissa;
  } ltir_thresh_t;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  pointer;
    logic [15:0] wdata;
  } ltir_req_t;

  typedef enum logic [1:0] {
    LTIR_CMP_INSIDE = 2'b00,
    LTIR_CMP_BELOW  = 2'b01,
    LTIR_CMP_ABOVE  = 2'b10
  } ltir_cmp_t;

endpackage
`default_nettype wire

// ==== ltir_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ltir_map.svh"

module ltir_regs #(
  // Arbitrary neutral identity values
  parameter logic [15:0] MAKER_CODE = 16'h00a5,
  parameter logic [15:0] PART_CODE  = 16'h0c3c
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  // Register access from the serial front end
  input  wire ltir_pkg::ltir_req_t   req_in,
  output var  logic [15:0]           rdata_out,
  output var  logic                  rvalid_out,
  // Measurement and configuration
  input  wire ltir_pkg::ltir_thresh_t result_raw_in,
  input  wire logic                  result_exponent_masking_in,
  input  wire logic [3:0]            range_code_in,
  // Result view, comparison outcome and threshold copies
  output var  ltir_pkg::ltir_thresh_t result_view_out,
  output var  logic                  above_threshold_flag_out,
  output var  logic                  below_threshold_flag_out,
  output var  ltir_pkg::ltir_thresh_t lower_threshold_out,
  output var  ltir_pkg::ltir_thresh_t upper_threshold_out
);
  import ltir_pkg::*;

  // ****************************************
  // Threshold storage
  // ****************************************
  ltir_thresh_t lower_threshold;
  ltir_thresh_t upper_threshold;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lower_threshold <= `LTIR_LOWER_RESET;
      upper_threshold <= `LTIR_UPPER_RESET;
    end else if (req_in.wr_en) begin
      // Identity pointers fall through untouched
      if (req_in.pointer == `LTIR_PTR_LOWER) begin
        lower_threshold <= req_in.wdata;
      end
      if (req_in.pointer == `LTIR_PTR_UPPER) begin
        upper_threshold <= req_in.wdata;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lower_threshold_out <= `LTIR_LOWER_RESET;
      upper_threshold_out <= `LTIR_UPPER_RESET;
    end else begin
      lower_threshold_out <= lower_threshold;
      upper_threshold_out <= upper_threshold;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [15:0] next_rdata;

  always_comb begin
    case (req_in.pointer)
      `LTIR_PTR_LOWER: next_rdata = lower_threshold;
      `LTIR_PTR_UPPER: next_rdata = upper_threshold;
      `LTIR_PTR_MAKER: next_rdata = MAKER_CODE;
      `LTIR_PTR_PART:  next_rdata = PART_CODE;
      default:         next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out  <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd_en;
      if (req_in.rd_en) begin
        rdata_out <= next_rdata;
      end
    end
  end

  // ****************************************
  // Lux scaling
  // ****************************************
  // Value is mantissa shifted by exponent; the 0.01 factor is common to all
  // three operands so it drops out of the comparison. Codes above 11 are
  // clamped to 11, the widest documented step.
  function automatic logic [26:0] ltir_to_lux(input ltir_thresh_t v);
    logic [3:0] e;
    e = (v.exponent > `LTIR_EXP_MAX) ? `LTIR_EXP_MAX : v.exponent;
    ltir_to_lux = {15'h0000, v.mantissa} << e;
  endfunction

  logic [26:0] lux_result;
  logic [26:0] lux_lower;
  logic [26:0] lux_upper;

  // Raw result feeds the compare so masking cannot steer the flags
  assign lux_result = ltir_to_lux(result_raw_in);
  assign lux_lower  = ltir_to_lux(lower_threshold);
  assign lux_upper  = ltir_to_lux(upper_threshold);

  ltir_cmp_t next_cmp;

  always_comb begin
    if (lux_result > lux_upper) begin
      next_cmp = LTIR_CMP_ABOVE;
    end else if (lux_result <= lux_lower) begin
      next_cmp = LTIR_CMP_BELOW;
    end else begin
      next_cmp = LTIR_CMP_INSIDE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      above_threshold_flag_out <= 1'b0;
      below_threshold_flag_out <= 1'b0;
    end else begin
      above_threshold_flag_out <= (next_cmp == LTIR_CMP_ABOVE);
      below_threshold_flag_out <= (next_cmp == LTIR_CMP_BELOW);
    end
  end

  // ****************************************
  // Result register view
  // ****************************************
  // The host is expected to program the manual range into both threshold
  // exponents when it relies on masking; nothing here depends on it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      result_view_out <= 16'h0000;
    end else begin
      result_view_out <= result_raw_in;
      if (result_exponent_masking_in && (range_code_in < `LTIR_EXP_MASK_LIM)) begin
        result_view_out.exponent <= 4'h0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Reference lux figures for the checks. They skip the clamp on purpose,
  // so they only mean something while every exponent involved is 11 or
  // below; the checks gate on that and the bench covers the codes above
  logic [26:0] ref_raw_lux;
  logic [26:0] ref_lower_lux;
  logic [26:0] ref_upper_lux;
  logic        ref_codes_plain;
  logic        ref_masking_on;

  assign ref_raw_lux     = 27'(result_raw_in.mantissa) << result_raw_in.exponent;
  assign ref_lower_lux   = 27'(lower_threshold.mantissa) << lower_threshold.exponent;
  assign ref_upper_lux   = 27'(upper_threshold.mantissa) << upper_threshold.exponent;
  assign ref_codes_plain = (result_raw_in.exponent < `LTIR_EXP_MASK_LIM)
                        && (lower_threshold.exponent < `LTIR_EXP_MASK_LIM)
                        && (upper_threshold.exponent < `LTIR_EXP_MASK_LIM);
  assign ref_masking_on  = result_exponent_masking_in
                        && (range_code_in < `LTIR_EXP_MASK_LIM);

  chk_lower_reset_val: assert property (@(posedge clk_in)
    sys_rst_in |=> lower_threshold == `LTIR_LOWER_RESET)
    else $error("lower threshold reset value wrong");

  chk_upper_reset_val: assert property (@(posedge clk_in)
    sys_rst_in |=> upper_threshold == `LTIR_UPPER_RESET)
    else $error("upper threshold reset value wrong");

  chk_lower_write_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer == `LTIR_PTR_LOWER) ##1 (req_in.rd_en && !req_in.wr_en
      && req_in.pointer == `LTIR_PTR_LOWER) |=> rdata_out == $past(req_in.wdata, 2))
    else $error("lower threshold readback mismatch");

  chk_maker_code_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.rd_en && req_in.pointer == `LTIR_PTR_MAKER) |=> rvalid_out && rdata_out == MAKER_CODE)
    else $error("maker code read wrong");

  chk_part_code_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.rd_en && req_in.pointer == `LTIR_PTR_PART) |=> rdata_out == PART_CODE)
    else $error("part code read wrong");

  chk_id_write_ignored: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer[7:1] == 7'h3f) |=>
      $stable(lower_threshold) && $stable(upper_threshold))
    else $error("identity write disturbed thresholds");

  chk_mask_exp_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (result_exponent_masking_in && range_code_in < `LTIR_EXP_MASK_LIM)
      |=> result_view_out.exponent == 4'h0)
    else $error("masked result exponent not zero");

  chk_above_flag_lux: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ((({15'h0000, result_raw_in.mantissa} << result_raw_in.exponent) >
      ({15'h0000, upper_threshold.mantissa} << upper_threshold.exponent))
      && result_raw_in.exponent < `LTIR_EXP_MASK_LIM
      && upper_threshold.exponent < `LTIR_EXP_MASK_LIM)
      |=> above_threshold_flag_out)
    else $error("above flag missed on unmasked result");

  // ****************************************
  // Flag and result view checks
  // ****************************************
  // Flags lag the operands by one edge, so every consequent looks one
  // cycle after the operands were seen
  chk_below_flag_lux: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ref_codes_plain && ref_raw_lux <= ref_lower_lux && ref_raw_lux <= ref_upper_lux)
      |=> below_threshold_flag_out)
    else $error("below flag missed on unmasked result");

  chk_inside_flags_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ref_codes_plain && ref_raw_lux > ref_lower_lux && ref_raw_lux <= ref_upper_lux)
      |=> !above_threshold_flag_out && !below_threshold_flag_out)
    else $error("flag raised while result lies between thresholds");

  chk_masked_above_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ref_masking_on && ref_codes_plain && ref_raw_lux > ref_upper_lux)
      |=> above_threshold_flag_out)
    else $error("masking suppressed the above flag");

  chk_masked_below_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ref_masking_on && ref_codes_plain && ref_raw_lux <= ref_lower_lux
      && ref_raw_lux <= ref_upper_lux) |=> below_threshold_flag_out)
    else $error("masking suppressed the below flag");

  chk_view_mantissa_pass: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    1'b1 |=> result_view_out.mantissa == $past(result_raw_in.mantissa))
    else $error("result view mantissa differs from raw result");

  chk_view_exp_pass: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ref_masking_on |=> result_view_out.exponent == $past(result_raw_in.exponent))
    else $error("result view exponent changed without masking");

  // ****************************************
  // Register path checks
  // ****************************************
  // Writes land on the strobe edge; the registered copies follow one
  // edge later, so they are checked two edges after the strobe
  chk_lower_write_lands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer == `LTIR_PTR_LOWER)
      |=> lower_threshold == $past(req_in.wdata))
    else $error("lower threshold write lost");

  chk_upper_write_lands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer == `LTIR_PTR_UPPER)
      |=> upper_threshold == $past(req_in.wdata))
    else $error("upper threshold write lost");

  // A read right behind a write of the same pointer must see the new word
  chk_upper_write_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer == `LTIR_PTR_UPPER) ##1 (req_in.rd_en && !req_in.wr_en
      && req_in.pointer == `LTIR_PTR_UPPER) |=> rdata_out == $past(req_in.wdata, 2))
    else $error("upper threshold readback mismatch");

  chk_lower_out_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer == `LTIR_PTR_LOWER)
      |=> ##1 lower_threshold_out == $past(req_in.wdata, 2))
    else $error("lower threshold copy does not follow write");

  chk_upper_out_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.wr_en && req_in.pointer == `LTIR_PTR_UPPER)
      |=> ##1 upper_threshold_out == $past(req_in.wdata, 2))
    else $error("upper threshold copy does not follow write");

  chk_lower_reset_out: assert property (@(posedge clk_in)
    sys_rst_in |=> lower_threshold_out == `LTIR_LOWER_RESET)
    else $error("lower threshold copy reset value wrong");

  chk_upper_reset_out: assert property (@(posedge clk_in)
    sys_rst_in |=> upper_threshold_out == `LTIR_UPPER_RESET)
    else $error("upper threshold copy reset value wrong");

  // Read data is a held register, so idle cycles must not disturb it
  chk_read_data_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !req_in.rd_en |=> $stable(rdata_out))
    else $error("read data moved without a read");

  chk_rvalid_idle_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !req_in.rd_en |=> !rvalid_out)
    else $error("read valid raised without a read");

  chk_part_read_valid: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (req_in.rd_en && req_in.pointer == `LTIR_PTR_PART) |=> rvalid_out)
    else $error("part code read not answered");

endmodule
`default_nettype wire

// ==== ltir_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the register access
// ****************************************
module ltir_host (
  input  wire logic                clk_in,
  output var  ltir_pkg::ltir_req_t req_out,
  input  wire logic [15:0]         rdata_in,
  input  wire logic                rvalid_in
);
  import ltir_pkg::*;
  logic [15:0] last;
  initial req_out = '0;
  // One request held across one rising edge; data is scrambled after release
  task automatic xfer(input logic wr, input logic [7:0] ptr, input logic [15:0] d);
    @(negedge clk_in);
    req_out = '{wr_en: wr, rd_en: !wr, pointer: ptr, wdata: d};
    @(negedge clk_in);
    req_out = '{wr_en: 1'b0, rd_en: 1'b0, pointer: ptr, wdata: ~d};
    last = rvalid_in ? rdata_in : ~last;
  endtask
  // Write then read the same pointer on the very next edge
  task automatic wr_rd(input logic [7:0] ptr, input logic [15:0] d);
    @(negedge clk_in);
    req_out = '{wr_en: 1'b1, rd_en: 1'b0, pointer: ptr, wdata: d};
    @(negedge clk_in);
    req_out = '{wr_en: 1'b0, rd_en: 1'b1, pointer: ptr, wdata: d};
    @(negedge clk_in);
    req_out = '{wr_en: 1'b0, rd_en: 1'b0, pointer: ptr, wdata: ~d};
    last = rvalid_in ? rdata_in : ~last;
  endtask
  // Manual range code copied into a threshold exponent
  function automatic logic [15:0] ranged(input logic [3:0] rc, input logic [11:0] m);
    return {rc, m};
  endfunction
endmodule
`default_nettype wire

// ==== ltir_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench for the threshold and identity registers
// ****************************************
module ltir_regs_tb_top;
  import ltir_pkg::*;
  localparam logic [15:0] MAKER = 16'h1234; // Arbitrary value
  localparam logic [15:0] PART  = 16'h5678; // Arbitrary value
  logic         clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         mask = 1'b0;
  logic [3:0]   range_code = 4'h0;
  ltir_req_t    req;
  ltir_thresh_t raw = '0;
  ltir_thresh_t view, lo_q, hi_q;
  logic [15:0]  rdata, lo, hi;
  logic         rvalid, above, below;
  logic [31:0]  seed = 32'h1697_5c3c;
  int           failures = 0;
  int           n_tests = 0;
  always #5 clk_in = ~clk_in;
  ltir_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) DUT (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
    .result_raw_in(raw), .result_exponent_masking_in(mask), .range_code_in(range_code),
    .result_view_out(view), .above_threshold_flag_out(above),
    .below_threshold_flag_out(below), .lower_threshold_out(lo_q), .upper_threshold_out(hi_q));
  ltir_host host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Common scale: codes above 11 act as 11
  function automatic logic [22:0] lux(input ltir_thresh_t v);
    return 23'(v.mantissa) << ((v.exponent > 4'hb) ? 4'hb : v.exponent);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
    host.xfer(1'b0, p, 16'h0000);
    chk(host.last, e);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rd_chk(8'h02, 16'h0000);
    rd_chk(8'h03, 16'hbfff);
    host.xfer(1'b1, 8'h04, 16'hffff);
    rd_chk(8'h04, 16'h0000);
    $display("reset and unmapped test done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      host.xfer(1'b1, 8'h7e, seed[15:0]);
      host.xfer(1'b1, 8'h7f, seed[31:16]);
      rd_chk(8'h7e, MAKER);
      rd_chk(8'h7f, PART);
    end
    $display("identity test done");
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      lo = (i < 12) ? host.ranged(4'(i), seed[11:0]) : seed[15:0];
      hi = (i < 12) ? host.ranged(4'(i), seed[27:16]) : seed[31:16];
      host.xfer(1'b1, 8'h02, lo);
      host.xfer(1'b1, 8'h03, hi);
      rd_chk(8'h02, lo);
      rd_chk(8'h03, hi);
      chk(lo_q, lo);
      chk(hi_q, hi);
      seed = lfsr(seed);
      raw = (i == 1) ? lo : seed[15:0];
      mask = seed[16];
      range_code = seed[20:17];
      repeat (2) @(negedge clk_in);
      chk({15'h0000, above}, {15'h0000, lux(raw) > lux(hi)});
      chk(16'(below), 16'(lux(raw) <= lux(lo) && lux(raw) <= lux(hi)));
      chk(view, {(mask && range_code < 4'hc) ? 4'h0 : raw.exponent, raw.mantissa});
    end
    $display("threshold test done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      host.wr_rd(8'h02, seed[15:0]);
      chk(host.last, seed[15:0]);
      host.wr_rd(8'h03, seed[31:16]);
      chk(host.last, seed[31:16]);
    end
    $display("back to back test done");
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk(lo_q, 16'h0000);
    chk(hi_q, 16'hbfff);
    rd_chk(8'h02, 16'h0000);
    rd_chk(8'h03, 16'hbfff);
    $display("mid-run reset test done");
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
